/* File: logic/pcp_consts.vh */
// Constants for the clock path configuration word
// How it works
// - Bit 33 powers down the band gap
// - Bit 32 selects internal driver bias resistor
// - Bits 31..29 enable rising surge legs
// - Bits 28..26 enable falling surge legs
// - Bit 25 routes lock detect to pin
// - Bit 24 picks lock or lead-lag meaning
// - Bit 23 powers down divider, direct path
// - Ratio codes 11,10,01,00 divide 8,4,2,1
// - Bit 20 powers down driver, resets set
// - Driver mux: idle, feedback, divout, divin
// - Bit 17 kills all surge current
// - Bit 16 selects core clock source
// - Feedback divider ratio is field plus one
// - Reference divider ratio is field plus one
// - Bit 5 reverses charge pump polarity
// - Bit 4 fully powers down charge pump
// - Bit 3 powers down pump output buffer
// - Pump current scale is field plus one
`ifndef PCP_CONSTS_VH
`define PCP_CONSTS_VH
`define PCP_WORD_W 40
`define PCP_BYTES 3'h5
`define PCP_RESET_VALUE 40'h00_0078_0000
`define PCP_USED_MASK 40'h83_FFFF_FF3F
`define PCP_BIT_DAC_PD 39
`define PCP_BIT_BG_PD 33
`define PCP_BIT_INT_RES 32
`define PCP_RISE_HI 31
`define PCP_RISE_LO 29
`define PCP_FALL_HI 28
`define PCP_FALL_LO 26
`define PCP_BIT_LD_EN 25
`define PCP_BIT_LD_MODE 24
`define PCP_BIT_DIV_PD 23
`define PCP_RATIO_HI 22
`define PCP_RATIO_LO 21
`define PCP_BIT_DRV_PD 20
`define PCP_MUX_HI 19
`define PCP_MUX_LO 18
`define PCP_BIT_NO_SURGE 17
`define PCP_BIT_SYS_SEL 16
`define PCP_NDIV_HI 15
`define PCP_NDIV_LO 12
`define PCP_MDIV_HI 11
`define PCP_MDIV_LO 8
`define PCP_BIT_CP_POL 5
`define PCP_BIT_CP_PD 4
`define PCP_BIT_CP_QPD 3
`define PCP_CPS_HI 2
`define PCP_CPS_LO 0
`define PCP_MUX_IDLE 2'h0
`define PCP_MUX_FB 2'h1
`define PCP_MUX_DIVOUT 2'h2
`define PCP_MUX_DIVIN 2'h3
`endif

/* File: logic/pcp_shift_reg.v */
// Byte assembler for the configuration word
`timescale 1ns/1ps
module pcp_shift_reg #(
    parameter NBYTES = 5
) (
    input wire core_clk,
    input wire rstn,
    input wire start,
    input wire byte_vld,
    input wire [7:0] byte_in,
    output reg [8*NBYTES-1:0] word_r,
    output reg done_r
);
    reg [2:0] cnt_r;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 3'h0;
            word_r <= {8*NBYTES{1'b0}};
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                cnt_r <= 3'h0;
            end else if (byte_vld) begin
                // Most significant byte first
                word_r <= {word_r[8*NBYTES-9:0], byte_in};
                if (cnt_r == NBYTES - 1) begin
                    cnt_r <= 3'h0;
                    done_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end
        end
    end
endmodule // pcp_shift_reg

/* File: logic/pcp_clock_path.v */
// Clock path configuration word and its decoded controls
`timescale 1ns/1ps
`include "pcp_consts.vh"
module pcp_clock_path (
    // Clock and reset
    input wire CORE_CLK,
    input wire RSTN,
    // Write port, one byte per strobe
    input wire WR_START,
    input wire WR_BYTE_VLD,
    input wire [7:0] WR_BYTE,
    output wire [39:0] RD_WORD,
    output wire WR_DONE,
    // Lock detector inputs, asynchronous
    input wire PLL_LOCKED,
    input wire FB_LAGS_REF,
    // Shared sync/status pin
    output wire STATUS_O,
    output wire STATUS_OE,
    // Band gap and bias resistor
    output wire BANDGAP_PD,
    output wire DRV_INT_RES_SEL,
    output wire DRIVER_BIAS_RESISTOR_PIN_EN,
    // Driver slew
    output wire [2:0] RISE_SURGE_EN,
    output wire [2:0] FALL_SURGE_EN,
    output wire DEFAULT_SURGE_EN,
    // Clock path
    output wire RF_DIV_PD,
    output wire RF_DIRECT_PATH_EN,
    output wire [3:0] RF_DIV_RATIO,
    output wire DRIVER_PD,
    output wire [1:0] DRIVER_MUX_SEL,
    output wire DRIVER_IDLE,
    output wire CORE_SYS_CLK_BYPASS,
    output wire [4:0] FB_DIV_N,
    output wire [4:0] REF_DIV_M,
    // Charge pump
    output wire CP_UP_ON_LAG,
    output wire CP_FULL_PD,
    output wire CP_QUICK_PD,
    output wire [3:0] CP_CURRENT_SCALE,
    output wire DAC_PD
);
    reg [39:0] cfg_r;
    wire [39:0] asm_word;
    wire asm_done;
    reg lock_s1_r, lock_s2_r, lag_s1_r, lag_s2_r;
    reg status_r;
    reg [3:0] ratio_r;

    // Host is trusted to send all five bytes
    pcp_shift_reg #(.NBYTES(5)) u_asm (
        .core_clk(CORE_CLK),
        .rstn(RSTN),
        .start(WR_START),
        .byte_vld(WR_BYTE_VLD),
        .byte_in(WR_BYTE),
        .word_r(asm_word),
        .done_r(asm_done)
    );

    // Word commits only once complete, so fields never tear
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_r <= `PCP_RESET_VALUE;
        end else if (asm_done) begin
            cfg_r <= asm_word & `PCP_USED_MASK;
        end
    end
    assign RD_WORD = cfg_r;
    assign WR_DONE = asm_done;

    // Two-stage synchronisers for lock detector levels
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            lag_s1_r <= 1'b0;
            lag_s2_r <= 1'b0;
            status_r <= 1'b0;
        end else begin
            lock_s1_r <= PLL_LOCKED;
            lock_s2_r <= lock_s1_r;
            lag_s1_r <= FB_LAGS_REF;
            lag_s2_r <= lag_s1_r;
            if (cfg_r[`PCP_BIT_LD_MODE]) begin
                status_r <= lag_s2_r;
            end else begin
                status_r <= ~lock_s2_r;
            end
        end
    end
    assign STATUS_O = cfg_r[`PCP_BIT_LD_EN] & status_r;
    assign STATUS_OE = cfg_r[`PCP_BIT_LD_EN];

    assign BANDGAP_PD = cfg_r[`PCP_BIT_BG_PD];
    assign DRV_INT_RES_SEL = cfg_r[`PCP_BIT_INT_RES];
    assign DRIVER_BIAS_RESISTOR_PIN_EN = ~cfg_r[`PCP_BIT_INT_RES];
    // No-surge bit overrides the extra legs too
    assign RISE_SURGE_EN = cfg_r[`PCP_BIT_NO_SURGE] ? 3'h0 :
        cfg_r[`PCP_RISE_HI:`PCP_RISE_LO];
    assign FALL_SURGE_EN = cfg_r[`PCP_BIT_NO_SURGE] ? 3'h0 :
        cfg_r[`PCP_FALL_HI:`PCP_FALL_LO];
    assign DEFAULT_SURGE_EN = ~cfg_r[`PCP_BIT_NO_SURGE];

    assign RF_DIV_PD = cfg_r[`PCP_BIT_DIV_PD];
    assign RF_DIRECT_PATH_EN = cfg_r[`PCP_BIT_DIV_PD];

    always @* begin
        case (cfg_r[`PCP_RATIO_HI:`PCP_RATIO_LO])
            2'h3: ratio_r = 4'h8;
            2'h2: ratio_r = 4'h4;
            2'h1: ratio_r = 4'h2;
            default: ratio_r = 4'h1;
        endcase
    end
    assign RF_DIV_RATIO = ratio_r;

    assign DRIVER_PD = cfg_r[`PCP_BIT_DRV_PD];
    assign DRIVER_MUX_SEL = cfg_r[`PCP_MUX_HI:`PCP_MUX_LO];
    assign DRIVER_IDLE = (DRIVER_MUX_SEL == `PCP_MUX_IDLE);
    assign CORE_SYS_CLK_BYPASS = cfg_r[`PCP_BIT_SYS_SEL];
    assign FB_DIV_N = {1'b0, cfg_r[`PCP_NDIV_HI:`PCP_NDIV_LO]} + 5'h01;
    assign REF_DIV_M = {1'b0, cfg_r[`PCP_MDIV_HI:`PCP_MDIV_LO]} + 5'h01;

    assign CP_UP_ON_LAG = ~cfg_r[`PCP_BIT_CP_POL];
    assign CP_FULL_PD = cfg_r[`PCP_BIT_CP_PD];
    assign CP_QUICK_PD = cfg_r[`PCP_BIT_CP_QPD];
    assign CP_CURRENT_SCALE = {1'b0, cfg_r[`PCP_CPS_HI:`PCP_CPS_LO]} + 4'h1;
    assign DAC_PD = cfg_r[`PCP_BIT_DAC_PD];
endmodule // pcp_clock_path

/* File: tb/pcp_clock_path_assertions.sv */
// Decode checker for the configuration word
`timescale 1ns/1ps
module pcp_checker (
    input wire logic CORE_CLK, RSTN, WR_DONE, BANDGAP_PD, STATUS_OE,
    input wire logic [39:0] RD_WORD,
    input wire logic [2:0] RISE_SURGE_EN,
    input wire logic [3:0] RF_DIV_RATIO, CP_CURRENT_SCALE,
    input wire logic [4:0] FB_DIV_N
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    a_bg_pd: assert property (BANDGAP_PD == RD_WORD[33])
        else $error("band gap");
    a_rise_leg: assert property (RISE_SURGE_EN == (RD_WORD[17] ? 3'h0 : RD_WORD[31:29]))
        else $error("rise legs");
    a_status_on: assert property (STATUS_OE == RD_WORD[25])
        else $error("status enable");
    a_rf_ratio: assert property (RF_DIV_RATIO == 4'h1 << RD_WORD[22:21])
        else $error("rf ratio");
    a_fb_div: assert property (FB_DIV_N == RD_WORD[15:12] + 5'h01)
        else $error("fb div");
    a_pump_scale: assert property (CP_CURRENT_SCALE == RD_WORD[2:0] + 4'h1)
        else $error("pump scale");
    a_unused_zero: assert property (WR_DONE |=> !RD_WORD[38:34] && !RD_WORD[7:6])
        else $error("unused bits");
    a_done_pulse: assert property (WR_DONE |=> !WR_DONE)
        else $error("done width");
endmodule // pcp_checker
bind pcp_clock_path pcp_checker pcp_checker_i (.*);

/* File: tb/pcp_far_side.sv */
// Far side model: lock and lead-lag levels
`timescale 1ns/1ps
module pcp_far_side (
    input wire logic lock_cmd,
    input wire logic lag_cmd,
    output wire logic locked,
    output wire logic lags
);
    // Off-grid delay, so the design's synchroniser sees a true async change
    assign #3 locked = lock_cmd;
    assign #3 lags = lag_cmd;
endmodule // pcp_far_side

/* File: tb/pcp_clock_path_test.sv */
// Bench for the clock path configuration word
`timescale 1ns/1ps
module pcp_clock_path_test;
    logic CORE_CLK, RSTN, WR_START, WR_BYTE_VLD, lock_cmd, lag_cmd;
    logic [7:0] WR_BYTE;
    wire [39:0] RD_WORD;
    wire [2:0] RISE_SURGE_EN, FALL_SURGE_EN;
    wire [3:0] RF_DIV_RATIO, CP_CURRENT_SCALE;
    wire [4:0] FB_DIV_N, REF_DIV_M;
    wire [1:0] DRIVER_MUX_SEL;
    wire WR_DONE, STATUS_O, STATUS_OE, BANDGAP_PD, DRV_INT_RES_SEL, DRIVER_BIAS_RESISTOR_PIN_EN,
        DEFAULT_SURGE_EN, RF_DIV_PD, RF_DIRECT_PATH_EN, DRIVER_PD, DRIVER_IDLE, PLL_LOCKED,
        FB_LAGS_REF, CORE_SYS_CLK_BYPASS, CP_UP_ON_LAG, CP_FULL_PD, CP_QUICK_PD, DAC_PD;
    int failures = 0, checks_done = 0, cyc = 0;
    pcp_clock_path pcp_clock_path_i (.*);
    pcp_far_side pcp_far_side_i (.lock_cmd(lock_cmd), .lag_cmd(lag_cmd), .locked(PLL_LOCKED),
        .lags(FB_LAGS_REF));
    task chk(input logic [39:0] g, e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Sends n bytes MSB first; fewer than five never commit
    task wr(input logic [39:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            WR_BYTE_VLD = 1;
            WR_BYTE = w[39-8*i -: 8];
            @(posedge CORE_CLK) #1;
        end
        WR_BYTE_VLD = 0;
        chk(WR_DONE, n == 5);
        @(posedge CORE_CLK) #1;
    endtask
    task t_ones;
        wr(40'h83_FFFF_FF3F, 5);
        chk(RD_WORD, 40'h83_FFFF_FF3F);
        chk(DAC_PD, 1'b1);
        chk({RISE_SURGE_EN, FALL_SURGE_EN, DEFAULT_SURGE_EN}, 7'h00);
        chk({FB_DIV_N, REF_DIV_M, CP_CURRENT_SCALE}, 14'h2108);
        chk({BANDGAP_PD, DRV_INT_RES_SEL, DRIVER_BIAS_RESISTOR_PIN_EN, CP_UP_ON_LAG}, 4'hC);
        chk({CP_FULL_PD, CP_QUICK_PD, RF_DIV_PD, RF_DIRECT_PATH_EN, CORE_SYS_CLK_BYPASS}, 5'h1F);
        wr(40'h00_0000_0000, 3);
        WR_START = 1;
        @(posedge CORE_CLK) #1;
        WR_START = 0;
        chk(RD_WORD, 40'h83_FFFF_FF3F);
    endtask
    // Extra legs with surge enabled, distinct divider fields
    task t_legs;
        wr(40'h00_AC00_3A00, 5);
        chk({RISE_SURGE_EN, FALL_SURGE_EN, DEFAULT_SURGE_EN}, 7'h57);
        chk({FB_DIV_N, REF_DIV_M}, 10'h08B);
        chk({STATUS_OE, STATUS_O, DAC_PD}, 3'h0);
    endtask
    task t_codes;
        for (int c = 0; c < 4; c++) begin
            wr({17'h0_0000, c[1:0], 1'b0, c[1:0], 18'h0_0000}, 5);
            chk(RF_DIV_RATIO, 4'h1 << c);
            chk({DRIVER_MUX_SEL, DRIVER_IDLE, DRIVER_PD}, {c[1:0], c == 0, 1'b0});
        end
    endtask
    // Lock change needs three edges; five gives margin
    task t_status(input logic [39:0] w, input logic lk, lg, exp);
        wr(w, 5);
        lock_cmd = lk;
        lag_cmd = lg;
        repeat (5) @(posedge CORE_CLK);
        #1;
        chk({STATUS_OE, STATUS_O}, {1'b1, exp});
    endtask
    task final_report;
        $display("failures %0d checks %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            final_report;
        end
    end
    initial begin
        CORE_CLK = 0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    initial begin
        {RSTN, WR_START, WR_BYTE_VLD, WR_BYTE, lock_cmd, lag_cmd} = 0;
        repeat (6) @(posedge CORE_CLK);
        #1;
        RSTN = 1;
        chk(RD_WORD, 40'h00_0078_0000);
        t_ones;
        t_legs;
        t_codes;
        t_status(40'h00_0200_0000, 1, 0, 0);
        t_status(40'h00_0200_0000, 0, 0, 1);
        t_status(40'h00_0300_0000, 0, 1, 1);
        t_status(40'h00_0300_0000, 1, 0, 0);
        final_report;
    end
endmodule // pcp_clock_path_test
